// ### dcs_regs_map.vh
`ifndef DCS_REGS_MAP_VH
`define DCS_REGS_MAP_VH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define DCS_ADDR_ENTRY_POINT   16'hf404
`define DCS_ADDR_RUN_STATE     16'hf405
`define DCS_ADDR_MGR_CLEAR     16'hf421
`define DCS_ADDR_PARITY_MASK   16'hf422
`define DCS_ADDR_CTRL          16'hf430
`define DCS_ADDR_PANIC_FLAG    16'hf431
`define DCS_ADDR_IRQ_STATUS    16'hf432
`define DCS_ADDR_IRQ_ENABLE    16'hf433
`define DCS_ADDR_IRQ_CLEAR     16'hf434

// ----------------------------------------------------------------------------
// Reset values and fields
// ----------------------------------------------------------------------------
`define DCS_RST_PARITY_MASK    12'h003
`define DCS_RST_ZERO           16'h0000
`define DCS_PARITY_MASK_BITS   12'hfff
`define DCS_CTRL_START_BIT     0
`define DCS_CTRL_STOP_BIT      1
`define DCS_CTRL_KILL_BIT      2
`define DCS_CLEAR_BIT          0

// ----------------------------------------------------------------------------
// Core state codes
// ----------------------------------------------------------------------------
`define DCS_ST_IDLE            3'h0
`define DCS_ST_RUN             3'h1
`define DCS_ST_PAUSE           3'h2
`define DCS_ST_SLEEP           3'h3
`define DCS_ST_STALL           3'h4

// ----------------------------------------------------------------------------
// Interrupt bits
// ----------------------------------------------------------------------------
`define DCS_IRQ_PANIC_BIT      0
`define DCS_IRQ_HALT_BIT       1
`define DCS_IRQ_WIDTH          2

`endif

// ### dcs_edge_detect.v
`timescale 1ns/1ps
`default_nettype none

// Rising-edge detector over a vector of software-written bits; the previous level is registered, the edge output is combinational.
module dcs_edge_detect
#(
  parameter WIDTH = 3
)
(
  // Clock and reset
  input  wire             mclk_i,
  input  wire             rst_n_i,
  // Level in, edge out
  input  wire [WIDTH-1:0] level_i,
  output wire [WIDTH-1:0] rise_o
);

  reg [WIDTH-1:0] prev_reg;

  always @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      prev_reg <= {WIDTH{1'b0}};
    else
      prev_reg <= level_i;
  end

  assign rise_o = level_i & ~prev_reg;

endmodule

`default_nettype wire

// ### dcs_core_status_regs.v
`timescale 1ns/1ps
`default_nettype none
`include "dcs_regs_map.vh"

module dcs_core_status_regs
(
  // Clock and reset
  input  wire        mclk_i,
  input  wire        rst_n_i,
  // Register port
  input  wire [15:0] reg_addr_i,
  input  wire [15:0] reg_wdata_i,
  input  wire        reg_wr_i,
  input  wire        reg_rd_i,
  output reg  [15:0] reg_rdata_o,
  // Core events
  input  wire        pause_instr_i,
  input  wire        sleep_instr_i,
  input  wire        sample_tick_i,
  input  wire        clock_resume_i,
  input  wire        multi_request_i,
  input  wire        frame_end_i,
  // Memory parity errors, one per memory
  input  wire [11:0] parity_err_i,
  // Core control outputs
  output reg         core_clk_en_o,
  output reg         pc_load_o,
  output reg  [15:0] pc_load_addr_o,
  output reg  [2:0]  core_state_o,
  // Panic manager
  output reg         panic_flag_o,
  output reg         panic_mgr_reset_o,
  output reg  [11:0] parity_report_o,
  // Interrupt
  output reg         irq_o
);

  // --------------------------------------------------------------------------
  // State machine encoding
  // --------------------------------------------------------------------------
  localparam [4:0] S_IDLE  = 5'h01;
  localparam [4:0] S_RUN   = 5'h02;
  localparam [4:0] S_PAUSE = 5'h04;
  localparam [4:0] S_SLEEP = 5'h08;
  localparam [4:0] S_STALL = 5'h10;

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  reg [15:0] entry_point_reg;
  reg [15:0] clear_reg;
  reg [11:0] parity_mask_reg;
  reg [2:0]  ctrl_reg;
  reg        stop_pending_reg;
  reg [4:0]  state_reg;
  reg [4:0]  state_next;
  reg        panic_reg;
  reg [`DCS_IRQ_WIDTH-1:0] irq_status_reg;
  reg [`DCS_IRQ_WIDTH-1:0] irq_enable_reg;
  reg [2:0]  state_code;

  wire [2:0]  ctrl_rise;
  wire        clear_rise;
  wire        start_rise;
  wire        stop_rise;
  wire        kill_rise;
  wire [11:0] parity_report;
  wire        error_seen;
  wire        wr_clear;
  wire        wr_irq_clear;
  wire        halt_event;
  wire [`DCS_IRQ_WIDTH-1:0] irq_events;

  // --------------------------------------------------------------------------
  // Edge detection of software strobes
  // --------------------------------------------------------------------------
  dcs_edge_detect
  #(
    .WIDTH (4)
  )
  u_edges
  (
    .mclk_i  (mclk_i),
    .rst_n_i (rst_n_i),
    .level_i ({clear_reg[`DCS_CLEAR_BIT], ctrl_reg}),
    .rise_o  ({clear_rise, ctrl_rise})
  );

  assign start_rise = ctrl_rise[`DCS_CTRL_START_BIT];
  assign stop_rise  = ctrl_rise[`DCS_CTRL_STOP_BIT];
  assign kill_rise  = ctrl_rise[`DCS_CTRL_KILL_BIT];

  // Unmasked errors reach the panic manager outputs one cycle later.
  assign parity_report = parity_err_i & ~parity_mask_reg;
  assign error_seen    = |parity_report;

  assign wr_clear     = reg_wr_i && (reg_addr_i == `DCS_ADDR_IRQ_CLEAR);
  assign halt_event   = (state_reg != S_IDLE) && (state_next == S_IDLE);
  assign irq_events   = {halt_event, error_seen};

  // --------------------------------------------------------------------------
  // Register writes
  // --------------------------------------------------------------------------
  always @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      entry_point_reg <= `DCS_RST_ZERO;
      clear_reg       <= `DCS_RST_ZERO;
      parity_mask_reg <= `DCS_RST_PARITY_MASK;
      ctrl_reg        <= 3'h0;
      irq_enable_reg  <= {`DCS_IRQ_WIDTH{1'b0}};
    end
    else if (reg_wr_i)
    begin
      // The core state address has no write case, so writes are ignored.
      case (reg_addr_i)
        `DCS_ADDR_ENTRY_POINT: entry_point_reg <= reg_wdata_i;
        `DCS_ADDR_MGR_CLEAR:   clear_reg       <= reg_wdata_i;
        `DCS_ADDR_PARITY_MASK: parity_mask_reg <= reg_wdata_i[11:0];
        `DCS_ADDR_CTRL:        ctrl_reg        <= reg_wdata_i[2:0];
        `DCS_ADDR_IRQ_ENABLE:
          irq_enable_reg <= reg_wdata_i[`DCS_IRQ_WIDTH-1:0];
        default:               ctrl_reg        <= ctrl_reg;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Core state machine
  // --------------------------------------------------------------------------
  always @*
  begin
    state_next = state_reg;
    case (state_reg)
      S_IDLE:
        if (start_rise)
          state_next = S_RUN;
      S_RUN:
        if (stop_pending_reg && frame_end_i)
          state_next = S_IDLE;
        else if (multi_request_i)
          state_next = S_STALL;
        else if (pause_instr_i)
          state_next = S_PAUSE;
        else if (sleep_instr_i)
          state_next = S_SLEEP;
      S_PAUSE:
        if (clock_resume_i)
          state_next = S_RUN;
      S_SLEEP:
        if (sample_tick_i)
          state_next = S_RUN;
      S_STALL:
        if (!multi_request_i)
          state_next = S_RUN;
      default:
        state_next = S_IDLE;
    endcase
    if (kill_rise)
      state_next = S_IDLE;
  end

  always @*
  begin
    case (state_next)
      S_RUN:   state_code = `DCS_ST_RUN;
      S_PAUSE: state_code = `DCS_ST_PAUSE;
      S_SLEEP: state_code = `DCS_ST_SLEEP;
      S_STALL: state_code = `DCS_ST_STALL;
      default: state_code = `DCS_ST_IDLE;
    endcase
  end

  always @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state_reg         <= S_IDLE;
      stop_pending_reg  <= 1'b0;
      core_state_o      <= `DCS_ST_IDLE;
      core_clk_en_o     <= 1'b0;
      pc_load_o         <= 1'b0;
      pc_load_addr_o    <= 16'h0000;
    end
    else
    begin
      state_reg     <= state_next;
      core_state_o  <= state_code;
      // Core clock is gated off while paused so core state is frozen.
      core_clk_en_o <= (state_next != S_IDLE) && (state_next != S_PAUSE);
      pc_load_o     <= (state_reg == S_IDLE) && (state_next == S_RUN);
      if ((state_reg == S_IDLE) && (state_next == S_RUN))
        pc_load_addr_o <= entry_point_reg;
      if (state_next == S_IDLE)
        stop_pending_reg <= 1'b0;
      else if (stop_rise)
        stop_pending_reg <= 1'b1;
    end
  end

  // --------------------------------------------------------------------------
  // Panic manager flag
  // --------------------------------------------------------------------------
  always @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      panic_reg         <= 1'b0;
      panic_flag_o      <= 1'b0;
      panic_mgr_reset_o <= 1'b0;
      parity_report_o   <= 12'h000;
    end
    else
    begin
      // An error in the clearing cycle keeps the flag set.
      if (error_seen)
        panic_reg <= 1'b1;
      else if (clear_rise)
        panic_reg <= 1'b0;
      panic_flag_o      <= error_seen | (panic_reg & ~clear_rise);
      panic_mgr_reset_o <= clear_rise;
      parity_report_o   <= parity_report;
    end
  end

  // --------------------------------------------------------------------------
  // Interrupt status, enable and clear
  // --------------------------------------------------------------------------
  assign wr_irq_clear = wr_clear;

  always @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      irq_status_reg <= {`DCS_IRQ_WIDTH{1'b0}};
      irq_o          <= 1'b0;
    end
    else
    begin
      // A new event wins over a clear in the same cycle.
      if (wr_irq_clear)
        irq_status_reg <= (irq_status_reg &
          ~reg_wdata_i[`DCS_IRQ_WIDTH-1:0]) | irq_events;
      else
        irq_status_reg <= irq_status_reg | irq_events;
      irq_o <= |(irq_status_reg & irq_enable_reg);
    end
  end

  // --------------------------------------------------------------------------
  // Read data, one cycle after the strobe
  // --------------------------------------------------------------------------
  always @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      reg_rdata_o <= 16'h0000;
    else if (reg_rd_i)
    begin
      case (reg_addr_i)
        `DCS_ADDR_ENTRY_POINT: reg_rdata_o <= entry_point_reg;
        `DCS_ADDR_RUN_STATE:   reg_rdata_o <= {13'h0000, core_state_o};
        `DCS_ADDR_MGR_CLEAR:   reg_rdata_o <= clear_reg;
        `DCS_ADDR_PARITY_MASK: reg_rdata_o <= {4'h0, parity_mask_reg};
        `DCS_ADDR_CTRL:        reg_rdata_o <= {13'h0000, ctrl_reg};
        `DCS_ADDR_PANIC_FLAG:  reg_rdata_o <= {15'h0000, panic_reg};
        `DCS_ADDR_IRQ_STATUS:  reg_rdata_o <= {14'h0000, irq_status_reg};
        `DCS_ADDR_IRQ_ENABLE:  reg_rdata_o <= {14'h0000, irq_enable_reg};
        default:               reg_rdata_o <= 16'h0000;
      endcase
    end
    else
      reg_rdata_o <= 16'h0000;
  end

endmodule

`default_nettype wire

// ### dcs_core_status_assertions.sv
`timescale 1ns/1ps
`default_nettype none

module dcs_core_status_assertions
(
  // Clock and reset
  input wire logic        mclk_i,
  input wire logic        rst_n_i,
  // Watched ports
  input wire logic        reg_rd_i,
  input wire logic [15:0] reg_addr_i,
  input wire logic [15:0] reg_rdata_o,
  input wire logic        multi_request_i,
  input wire logic [11:0] parity_err_i,
  input wire logic        core_clk_en_o,
  input wire logic        pc_load_o,
  input wire logic [2:0]  core_state_o,
  input wire logic        panic_flag_o,
  input wire logic        panic_mgr_reset_o,
  input wire logic [11:0] parity_report_o
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_n_i);

  property p_pc_load;
    pc_load_o |-> (core_state_o == 3'h1 && $past(core_state_o) == 3'h0)
      ##1 !pc_load_o;
  endproperty
  a_pc_load: assert property (p_pc_load) else $error("bad pc load");
  property p_state_code;
    core_state_o <= 3'h4 &&
      core_clk_en_o == (core_state_o != 3'h0 && core_state_o != 3'h2);
  endproperty
  a_state_code: assert property (p_state_code) else $error("bad code");
  property p_pause_gate;
    core_state_o == 3'h2 |-> !core_clk_en_o;
  endproperty
  a_pause_gate: assert property (p_pause_gate) else $error("clk on");
  property p_stall_leave;
    core_state_o == 3'h4 && !multi_request_i |=> core_state_o == 3'h1;
  endproperty
  a_stall_leave: assert property (p_stall_leave) else $error("stall");
  property p_read_state;
    reg_rd_i && reg_addr_i == 16'hf405 |=>
      reg_rdata_o == {13'h0, $past(core_state_o)};
  endproperty
  a_read_state: assert property (p_read_state) else $error("state rd");
  property p_report_cause;
    (parity_report_o & ~$past(parity_err_i)) == 12'h0;
  endproperty
  a_report_cause: assert property (p_report_cause) else $error("rep");
  property p_flag_set;
    |parity_report_o |-> panic_flag_o;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("flag low");
  property p_flag_hold;
    $fell(panic_flag_o) |-> panic_mgr_reset_o || $past(panic_mgr_reset_o);
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag fell");
  property p_mgr_pulse;
    panic_mgr_reset_o |=> !panic_mgr_reset_o;
  endproperty
  a_mgr_pulse: assert property (p_mgr_pulse) else $error("long pulse");
  c_pause: cover property (core_state_o == 3'h2);
  c_stall: cover property (core_state_o == 3'h4);
  c_panic: cover property ($rose(panic_flag_o));
endmodule

bind dcs_core_status_regs dcs_core_status_assertions u_chk
(
  .mclk_i(mclk_i), .rst_n_i(rst_n_i), .reg_rd_i(reg_rd_i),
  .reg_addr_i(reg_addr_i), .reg_rdata_o(reg_rdata_o),
  .multi_request_i(multi_request_i), .parity_err_i(parity_err_i),
  .core_clk_en_o(core_clk_en_o), .pc_load_o(pc_load_o),
  .core_state_o(core_state_o), .panic_flag_o(panic_flag_o),
  .panic_mgr_reset_o(panic_mgr_reset_o), .parity_report_o(parity_report_o)
);

`default_nettype wire

// ### tb_dcs_core_status_regs.sv
`timescale 1ns/1ps
`default_nettype none

module tb_dcs_core_status_regs;
  logic        mclk_i, rst_n_i, reg_wr_i, reg_rd_i, pause_instr_i;
  logic [15:0] reg_addr_i, reg_wdata_i, reg_rdata_o, pc_load_addr_o;
  logic        sleep_instr_i, sample_tick_i, clock_resume_i, frame_end_i;
  logic        multi_request_i, core_clk_en_o, pc_load_o, irq_o;
  logic [11:0] parity_err_i, parity_report_o;
  logic [2:0]  core_state_o;
  logic        panic_flag_o, panic_mgr_reset_o;
  int          bad_count, compares;

  dcs_core_status_regs dut
  (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .pause_instr_i(pause_instr_i),
    .sleep_instr_i(sleep_instr_i), .sample_tick_i(sample_tick_i),
    .clock_resume_i(clock_resume_i), .multi_request_i(multi_request_i),
    .frame_end_i(frame_end_i), .parity_err_i(parity_err_i),
    .core_clk_en_o(core_clk_en_o), .pc_load_o(pc_load_o),
    .pc_load_addr_o(pc_load_addr_o), .core_state_o(core_state_o),
    .panic_flag_o(panic_flag_o), .panic_mgr_reset_o(panic_mgr_reset_o),
    .parity_report_o(parity_report_o), .irq_o(irq_o)
  );

  initial
  begin
    mclk_i = 1'b0;
    forever #25 mclk_i = ~mclk_i;
  end

  task automatic chk(input string n, input logic [15:0] e, g);
    compares++;
    if (g !== e)
    begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wr(input logic [15:0] a, d);
    @(posedge mclk_i);
    reg_wr_i    <= 1'b1;
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    @(posedge mclk_i);
    reg_wr_i    <= 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, e);
    @(posedge mclk_i);
    reg_rd_i   <= 1'b1;
    reg_addr_i <= a;
    @(posedge mclk_i);
    reg_rd_i   <= 1'b0;
    #1 chk("rdata", e, reg_rdata_o);
  endtask

  // Waits a bounded time for the core state, then compares it.
  task automatic st(input logic [2:0] e);
    int n;
    n = 0;
    while (core_state_o !== e && n < 8)
    begin
      @(posedge mclk_i);
      #1 n++;
    end
    chk("state", {13'h0, e}, {13'h0, core_state_o});
  endtask

  task automatic perr(input logic [11:0] v, e);
    @(posedge mclk_i) parity_err_i <= v;
    @(posedge mclk_i) parity_err_i <= 12'h0;
    #1 chk("report", {4'h0, e}, {4'h0, parity_report_o});
  endtask

  task automatic flag(input logic e);
    repeat (3) @(posedge mclk_i);
    #1 chk("flag", {15'h0, e}, {15'h0, panic_flag_o});
  endtask

  task automatic end_sim();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial
  begin
    #200000;
    bad_count++;
    end_sim();
  end

  initial
  begin
    {rst_n_i, reg_wr_i, reg_rd_i, pause_instr_i, sleep_instr_i} = '0;
    {sample_tick_i, clock_resume_i, multi_request_i, frame_end_i} = '0;
    {reg_addr_i, reg_wdata_i, parity_err_i} = '0;
    repeat (16) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    rd(16'hf405, 16'h0000);
    rd(16'hf422, 16'h0003);
    rd(16'hf404, 16'h0000);
    rd(16'hf500, 16'h0000);
    perr(12'h003, 12'h000);
    flag(1'b0);
    wr(16'hf422, 16'hffff);
    rd(16'hf422, 16'h0fff);
    wr(16'hf404, 16'h1234);
    wr(16'hf430, 16'h0001);
    st(3'h1);
    chk("pc_addr", 16'h1234, pc_load_addr_o);
    wr(16'hf405, 16'h0007);
    rd(16'hf405, 16'h0001);
    @(posedge mclk_i) pause_instr_i <= 1'b1;
    @(posedge mclk_i) pause_instr_i <= 1'b0;
    st(3'h2);
    chk("clk_en", 16'h0, {15'h0, core_clk_en_o});
    @(posedge mclk_i) clock_resume_i <= 1'b1;
    @(posedge mclk_i) clock_resume_i <= 1'b0;
    st(3'h1);
    @(posedge mclk_i) sleep_instr_i <= 1'b1;
    @(posedge mclk_i) sleep_instr_i <= 1'b0;
    st(3'h3);
    @(posedge mclk_i) sample_tick_i <= 1'b1;
    @(posedge mclk_i) sample_tick_i <= 1'b0;
    st(3'h1);
    @(posedge mclk_i) multi_request_i <= 1'b1;
    st(3'h4);
    rd(16'hf405, 16'h0004);
    @(posedge mclk_i) multi_request_i <= 1'b0;
    st(3'h1);
    wr(16'hf430, 16'h0005);
    st(3'h0);
    rd(16'hf432, 16'h0002);
    wr(16'hf430, 16'h0000);
    wr(16'hf430, 16'h0001);
    st(3'h1);
    chk("pc_load", 16'h1, {15'h0, pc_load_o});
    wr(16'hf430, 16'h0003);
    repeat (4) @(posedge mclk_i);
    st(3'h1);
    @(posedge mclk_i) frame_end_i <= 1'b1;
    @(posedge mclk_i) frame_end_i <= 1'b0;
    st(3'h0);
    wr(16'hf434, 16'h0003);
    wr(16'hf433, 16'h0001);
    for (int i = 0; i < 12; i++)
    begin
      wr(16'hf422, {4'h0, 12'hfff ^ (12'h1 << i)});
      perr(12'hfff ^ (12'h1 << i), 12'h0);
      flag(1'b0);
      perr(12'hfff, 12'h1 << i);
      flag(1'b1);
      wr(16'hf421, 16'h0001);
      wr(16'hf421, 16'h0000);
      flag(1'b0);
    end
    perr(12'h800, 12'h800);
    wr(16'hf421, 16'h0001);
    @(posedge mclk_i) #1 chk("mgr_reset", 16'h1, {15'h0, panic_mgr_reset_o});
    flag(1'b0);
    perr(12'h800, 12'h800);
    wr(16'hf421, 16'h0001);
    flag(1'b1);
    wr(16'hf421, 16'h0000);
    flag(1'b1);
    wr(16'hf421, 16'h0001);
    flag(1'b0);
    chk("irq", 16'h1, {15'h0, irq_o});
    rd(16'hf432, 16'h0001);
    wr(16'hf433, 16'h0000);
    flag(1'b0);
    chk("irq", 16'h0, {15'h0, irq_o});
    wr(16'hf433, 16'h0001);
    wr(16'hf434, 16'h0001);
    flag(1'b0);
    chk("irq", 16'h0, {15'h0, irq_o});
    rd(16'hf432, 16'h0000);
    end_sim();
  end
endmodule

`default_nettype wire
